/* adcc_pkg.sv */
// package of register map, field positions, codes and timing for the converter control block
package adcc_pkg;

	// register word offsets (byte addresses on the register bus)
	localparam logic [3:0] OFF_CONTROL_ZERO  = 4'h0;
	localparam logic [3:0] OFF_CONTROL_ONE   = 4'h4;
	localparam logic [3:0] OFF_CONTROL_TWO   = 4'h8;
	localparam logic [3:0] OFF_RESULT_HIGH   = 4'hC;
	localparam logic [7:0] OFF_RESULT_LOW    = 8'h10;

	// reset values
	localparam logic [7:0] RST_CONTROL_ZERO  = 8'h00;
	localparam logic [7:0] RST_CONTROL_ONE   = 8'h00;
	localparam logic [7:0] RST_CONTROL_TWO   = 8'h00;
	localparam logic [7:0] RST_RESULT        = 8'h00;

	// field positions in control zero
	localparam int POS_CONVERTER_ON     = 0;
	localparam int POS_GO_DONE          = 1;
	localparam int POS_PCHAN_LO         = 2;
	localparam int POS_RESULT_WIDTH     = 7;
	// field positions in control one
	localparam int POS_POS_REF_LO       = 0;
	localparam int POS_NEG_REF          = 2;
	localparam int POS_UNIMPL           = 3;
	localparam int POS_CLK_SEL_LO       = 4;
	localparam int POS_FORMAT           = 7;
	// field positions in control two
	localparam int POS_NCHAN_LO         = 0;
	localparam int POS_TRIG_LO          = 4;
	// mask of writable bits in control one
	localparam logic [7:0] MASK_CONTROL_ONE = 8'hF7;

	// positive channel codes
	localparam logic [4:0] PCH_AN13     = 5'h0D;
	localparam logic [4:0] PCH_AN21     = 5'h15;
	localparam logic [4:0] PCH_DAC4     = 5'h18;
	localparam logic [4:0] PCH_DAC3     = 5'h19;
	localparam logic [4:0] PCH_DAC2     = 5'h1C;
	localparam logic [4:0] PCH_TEMP     = 5'h1D;
	localparam logic [4:0] PCH_DAC      = 5'h1E;
	localparam logic [4:0] PCH_FIXED    = 5'h1F;
	// negative channel codes
	localparam logic [3:0] NCH_AN13     = 4'hD;
	localparam logic [3:0] NCH_AN21     = 4'hE;
	localparam logic [3:0] NCH_NEG_REF  = 4'hF;

	// one-hot source selects seen by the analog multiplexers
	localparam int SRC_ANALOG_INPUTS    = 22;
	localparam int SRC_DAC_MAIN         = 22;
	localparam int SRC_DAC2             = 23;
	localparam int SRC_DAC3             = 24;
	localparam int SRC_DAC4             = 25;
	localparam int SRC_TEMP             = 26;
	localparam int SRC_FIXED_REF        = 27;
	localparam int SRC_NEG_REF          = 28;
	localparam int SRC_W                = 29;
	localparam logic [SRC_W-1:0] SRC_NONE = 29'h0000_0000;
	localparam logic [SRC_W-1:0] SRC_ONE  = 29'h0000_0001;

	// conversion clock codes
	localparam logic [2:0] CLK_DIV2     = 3'h0;
	localparam logic [2:0] CLK_DIV8     = 3'h1;
	localparam logic [2:0] CLK_DIV32    = 3'h2;
	localparam logic [2:0] CLK_RC_A     = 3'h3;
	localparam logic [2:0] CLK_DIV4     = 3'h4;
	localparam logic [2:0] CLK_DIV16    = 3'h5;
	localparam logic [2:0] CLK_DIV64    = 3'h6;
	localparam logic [2:0] CLK_RC_B     = 3'h7;

	// positive reference codes
	localparam logic [1:0] PREF_SUPPLY  = 2'h0;
	localparam logic [1:0] PREF_PIN     = 2'h1;
	localparam logic [1:0] PREF_RSVD    = 2'h2;
	localparam logic [1:0] PREF_FIXED   = 2'h3;

	// trigger source lines: index of each event on the trigger input bus
	localparam int TRG_W                = 11;
	localparam int TRG_CCU1             = 0;
	localparam int TRG_CCU2             = 1;
	localparam int TRG_PWM1_PERIOD      = 2;
	localparam int TRG_PWM1_RISE        = 3;
	localparam int TRG_PWM1_FALL        = 4;
	localparam int TRG_PWM2_PERIOD      = 5;
	localparam int TRG_PWM2_RISE        = 6;
	localparam int TRG_PWM2_FALL        = 7;
	localparam int TRG_PWM4_PERIOD      = 8;
	localparam int TRG_PWM4_RISE        = 9;
	localparam int TRG_PWM4_FALL        = 10;

	// converter handshake states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_START = 2'b01,
		ST_BUSY  = 2'b10
	} adcc_state_e;

endpackage

/* adcc_clkdiv.sv */
// conversion clock divider: one-cycle tick at the selected rate
`timescale 1ns/1ps
`default_nettype none

module adcc_clkdiv
	import adcc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic       run,
	input  wire logic [2:0] sel,
	output var  logic       tick,
	output var  logic       use_rc
);

	typedef struct packed {
		logic [5:0] cnt;
		logic       tick;
		logic       use_rc;
	} adcc_div_s;

	adcc_div_s r;
	adcc_div_s next_r;
	logic [5:0] last;

	always_comb begin
		unique case (sel)
			CLK_DIV2:  last = 6'h01;
			CLK_DIV8:  last = 6'h07;
			CLK_DIV32: last = 6'h1F;
			CLK_DIV4:  last = 6'h03;
			CLK_DIV16: last = 6'h0F;
			CLK_DIV64: last = 6'h3F;
			default:   last = 6'h00;
		endcase
	end

	always_comb begin
		next_r = r;
		next_r.use_rc = (sel == CLK_RC_A) || (sel == CLK_RC_B);
		next_r.tick = 1'b0;
		if (!run || next_r.use_rc) begin
			next_r.cnt = 6'h00;
		end else if (r.cnt >= last) begin
			next_r.cnt = 6'h00;
			next_r.tick = 1'b1;
		end else begin
			next_r.cnt = r.cnt + 6'h01;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r <= '0;
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign tick = r.tick;
	assign use_rc = r.use_rc;

endmodule

`default_nettype wire

/* adcc_top.sv */
// converter control registers, go/done handshake, channel and reference selection
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - width bit one gives ten-bit result layout
// - positive codes 0-13 and 21 pick inputs
// - top positive codes pick internal sources
// - reserved positive codes connect nothing
// - writing go starts; reads one while busy
// - hardware clears go when conversion completes
// - enable bit powers the converter
// - format bit picks two's complement or sign-magnitude
// - clock select divides system clock or RC
// - negative reference bit picks pin or ground
// - positive reference field picks supply, pin, fixed
// - trigger codes 0000/0011 off, 0001/0010 capture units
// - trigger codes pick pwm controller events
// - negative codes pick inputs or negative reference
// - converter off disconnects every multiplexer input
// - sign-magnitude high byte holds magnitude 11:4
// - starting conversion clears both result bytes
// - completion raises conversion done flag
// - early clear discards result, bytes stay cleared
// - trigger rising edge sets go
module adcc_top
	import adcc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              ce,
	input  wire logic [4:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output var  logic [31:0]       avs_readdata,
	output var  logic              avs_waitrequest,
	input  wire logic [TRG_W-1:0]  trigger_in,
	input  wire logic              conv_done,
	input  wire logic              conv_sign,
	input  wire logic [11:0]       conv_magnitude,
	output var  logic              converter_on,
	output var  logic              conv_start,
	output var  logic              conv_abort,
	output var  logic              conv_clk_tick,
	output var  logic              conv_clk_use_rc,
	output var  logic [SRC_W-1:0]  pos_mux_select,
	output var  logic [SRC_W-1:0]  neg_mux_select,
	output var  logic              neg_ref_pin,
	output var  logic [1:0]        pos_ref_select,
	output var  logic              conversion_done_flag
);

	typedef struct packed {
		logic [7:0]       ctl0;
		logic [7:0]       ctl1;
		logic [7:0]       ctl2;
		logic [7:0]       res_hi;
		logic [7:0]       res_lo;
		adcc_state_e      st;
		logic             trig_prev;
		logic             ack;
		logic             wreq;
		logic [31:0]      rdata;
		logic             start;
		logic             abort;
		logic [SRC_W-1:0] pmux;
		logic [SRC_W-1:0] nmux;
		logic             done_flag;
	} adcc_reg_s;

	adcc_reg_s r;
	adcc_reg_s next_r;

	logic       trig_sel;
	logic       bus_req;
	logic       wr_hit;
	logic [4:0] pch;
	logic [3:0] nch;
	logic [7:0] fmt_hi;
	logic [7:0] fmt_lo;
	logic [12:0] twos;

	////////////////////////////////////////////////////////////////////////////////
	// trigger source selection

	always_comb begin
		unique case (r.ctl2[POS_TRIG_LO +: 4])
			4'h1:    trig_sel = trigger_in[TRG_CCU1];
			4'h2:    trig_sel = trigger_in[TRG_CCU2];
			4'h4:    trig_sel = trigger_in[TRG_PWM1_PERIOD];
			4'h5:    trig_sel = trigger_in[TRG_PWM1_RISE];
			4'h6:    trig_sel = trigger_in[TRG_PWM1_FALL];
			4'h7:    trig_sel = trigger_in[TRG_PWM2_PERIOD];
			4'h8:    trig_sel = trigger_in[TRG_PWM2_RISE];
			4'h9:    trig_sel = trigger_in[TRG_PWM2_FALL];
			4'hD:    trig_sel = trigger_in[TRG_PWM4_PERIOD];
			4'hE:    trig_sel = trigger_in[TRG_PWM4_RISE];
			4'hF:    trig_sel = trigger_in[TRG_PWM4_FALL];
			default: trig_sel = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// result formatting

	always_comb begin
		twos = conv_sign ? {1'b1, 12'h000 - conv_magnitude} : {1'b0, conv_magnitude};
		if (r.ctl1[POS_FORMAT]) begin
			// two's complement, right justified, sign extended
			if (r.ctl0[POS_RESULT_WIDTH]) begin
				fmt_hi = {{5{twos[12]}}, twos[12:10]};
				fmt_lo = twos[9:2];
			end else begin
				fmt_hi = {{4{twos[12]}}, twos[11:8]};
				fmt_lo = twos[7:0];
			end
		end else begin
			fmt_hi = conv_magnitude[11:4];
			if (r.ctl0[POS_RESULT_WIDTH]) begin
				fmt_lo = {conv_magnitude[3:2], 5'h00, conv_sign};
			end else begin
				fmt_lo = {conv_magnitude[3:0], 3'h0, conv_sign};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// channel multiplexer decode

	always_comb begin
		pch = r.ctl0[POS_PCHAN_LO +: 5];
		nch = r.ctl2[POS_NCHAN_LO +: 4];
		next_r = r;
		next_r.pmux = SRC_NONE;
		next_r.nmux = SRC_NONE;
		if (r.ctl0[POS_CONVERTER_ON]) begin
			if (pch <= PCH_AN13) begin
				next_r.pmux = SRC_ONE << pch;
			end else begin
				unique case (pch)
					PCH_AN21:  next_r.pmux = SRC_ONE << 21;
					PCH_FIXED: next_r.pmux = SRC_ONE << SRC_FIXED_REF;
					PCH_DAC:   next_r.pmux = SRC_ONE << SRC_DAC_MAIN;
					PCH_TEMP:  next_r.pmux = SRC_ONE << SRC_TEMP;
					PCH_DAC2:  next_r.pmux = SRC_ONE << SRC_DAC2;
					PCH_DAC3:  next_r.pmux = SRC_ONE << SRC_DAC3;
					PCH_DAC4:  next_r.pmux = SRC_ONE << SRC_DAC4;
					default:   next_r.pmux = SRC_NONE;
				endcase
			end
			if (nch <= NCH_AN13) begin
				next_r.nmux = SRC_ONE << nch;
			end else if (nch == NCH_AN21) begin
				next_r.nmux = SRC_ONE << 21;
			end else begin
				next_r.nmux = SRC_ONE << SRC_NEG_REF;
			end
		end

		////////////////////////////////////////////////////////////////////////
		// bus slave: one wait cycle, answer on the second edge
		bus_req = avs_read || avs_write;
		wr_hit = avs_write && r.ack && avs_byteenable[0];
		next_r.ack = bus_req && !r.ack;
		next_r.wreq = !next_r.ack;
		next_r.start = 1'b0;
		next_r.abort = 1'b0;
		next_r.trig_prev = trig_sel;

		if (avs_read && !r.ack) begin
			unique case ({3'h0, avs_address})
				{4'h0, OFF_CONTROL_ZERO}: next_r.rdata = {24'h000000, r.ctl0};
				{4'h0, OFF_CONTROL_ONE}:  next_r.rdata = {24'h000000, r.ctl1};
				{4'h0, OFF_CONTROL_TWO}:  next_r.rdata = {24'h000000, r.ctl2};
				{4'h0, OFF_RESULT_HIGH}:  next_r.rdata = {24'h000000, r.res_hi};
				OFF_RESULT_LOW:           next_r.rdata = {24'h000000, r.res_lo};
				default:                  next_r.rdata = 32'h0000_0000;
			endcase
		end

		if (wr_hit) begin
			unique case ({3'h0, avs_address})
				{4'h0, OFF_CONTROL_ZERO}: next_r.ctl0 = avs_writedata[7:0];
				{4'h0, OFF_CONTROL_ONE}:  next_r.ctl1 = avs_writedata[7:0] & MASK_CONTROL_ONE;
				{4'h0, OFF_CONTROL_TWO}:  next_r.ctl2 = avs_writedata[7:0];
				{4'h0, OFF_RESULT_HIGH}:  next_r.res_hi = avs_writedata[7:0];
				OFF_RESULT_LOW:           next_r.res_lo = avs_writedata[7:0];
				default:                  next_r.rdata = r.rdata;
			endcase
		end

		// rising trigger edge sets go while idle and enabled
		if (trig_sel && !r.trig_prev && r.st == ST_IDLE && next_r.ctl0[POS_CONVERTER_ON]) begin
			next_r.ctl0[POS_GO_DONE] = 1'b1;
		end

		////////////////////////////////////////////////////////////////////////
		// conversion handshake
		unique case (r.st)
			ST_IDLE: begin
				if (next_r.ctl0[POS_GO_DONE] && next_r.ctl0[POS_CONVERTER_ON]) begin
					next_r.res_hi = RST_RESULT;
					next_r.res_lo = RST_RESULT;
					next_r.start = 1'b1;
					next_r.st = ST_BUSY;
				end else begin
					next_r.ctl0[POS_GO_DONE] = 1'b0;
				end
			end
			ST_BUSY: begin
				if (!next_r.ctl0[POS_GO_DONE] || !next_r.ctl0[POS_CONVERTER_ON]) begin
					next_r.abort = 1'b1;
					next_r.ctl0[POS_GO_DONE] = 1'b0;
					next_r.st = ST_IDLE;
				end else if (conv_done) begin
					next_r.res_hi = fmt_hi;
					next_r.res_lo = fmt_lo;
					next_r.ctl0[POS_GO_DONE] = 1'b0;
					next_r.done_flag = 1'b1;
					next_r.st = ST_IDLE;
				end
			end
			default: begin
				next_r.st = ST_IDLE;
			end
		endcase
		if (r.st == ST_IDLE && r.done_flag && wr_hit
			&& {3'h0, avs_address} == {4'h0, OFF_CONTROL_ZERO}
			&& avs_writedata[POS_GO_DONE]) begin
			next_r.done_flag = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r <= '{ctl0: RST_CONTROL_ZERO, ctl1: RST_CONTROL_ONE, ctl2: RST_CONTROL_TWO,
				res_hi: RST_RESULT, res_lo: RST_RESULT, st: ST_IDLE, trig_prev: 1'b0,
				ack: 1'b0, wreq: 1'b1, rdata: 32'h0000_0000, start: 1'b0, abort: 1'b0,
				pmux: SRC_NONE, nmux: SRC_NONE, done_flag: 1'b0};
		end else if (ce) begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// conversion clock

	adcc_clkdiv u_div (
		.clk    (clk),
		.rst    (rst),
		.ce     (ce),
		.run    (r.ctl0[POS_CONVERTER_ON]),
		.sel    (r.ctl1[POS_CLK_SEL_LO +: 3]),
		.tick   (conv_clk_tick),
		.use_rc (conv_clk_use_rc)
	);

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign avs_readdata = r.rdata;
	assign avs_waitrequest = r.wreq;
	assign converter_on = r.ctl0[POS_CONVERTER_ON];
	assign conv_start = r.start;
	assign conv_abort = r.abort;
	assign pos_mux_select = r.pmux;
	assign neg_mux_select = r.nmux;
	assign neg_ref_pin = r.ctl1[POS_NEG_REF];
	assign pos_ref_select = r.ctl1[POS_POS_REF_LO +: 2];
	assign conversion_done_flag = r.done_flag;

endmodule

`default_nettype wire

/* adcc_conv_model.sv */
// behavioural model of the analog converter core behind the control block
`timescale 1ns/1ps
`default_nettype none

module adcc_conv_model
	import adcc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        conv_start,
	input  wire logic        conv_abort,
	input  wire logic [7:0]  latency,
	input  wire logic [12:0] sample,
	output var  logic        conv_done,
	output var  logic        conv_sign,
	output var  logic [11:0] conv_magnitude
);
	logic [7:0] cnt;
	logic       busy;

	// result lines only carry the sample in the done cycle, inverse otherwise
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			cnt <= 8'h00;
			conv_done <= 1'b0;
			{conv_sign, conv_magnitude} <= 13'h0000;
		end else begin
			conv_done <= 1'b0;
			{conv_sign, conv_magnitude} <= ~sample;
			if (conv_start) begin
				busy <= 1'b1;
				cnt <= 8'h00;
			end else if (conv_abort) begin
				busy <= 1'b0;
			end else if (busy) begin
				cnt <= cnt + 8'h01;
				if (cnt + 8'h01 >= latency) begin
					busy <= 1'b0;
					conv_done <= 1'b1;
					{conv_sign, conv_magnitude} <= sample;
				end
			end
		end
	end
endmodule

`default_nettype wire

/* adcc_top_monitor.sv */
// checker of bus handshake, conversion pulses, clock ticks and multiplexer selects
`timescale 1ns/1ps
`default_nettype none

module adcc_top_monitor
	import adcc_pkg::*;
(
	input wire logic             clk,
	input wire logic             rst,
	input wire logic             ce,
	input wire logic             avs_read,
	input wire logic             avs_write,
	input wire logic             avs_waitrequest,
	input wire logic             conv_done,
	input wire logic             converter_on,
	input wire logic             conv_start,
	input wire logic             conv_abort,
	input wire logic             conv_clk_tick,
	input wire logic             conv_clk_use_rc,
	input wire logic [SRC_W-1:0] pos_mux_select,
	input wire logic [SRC_W-1:0] neg_mux_select,
	input wire logic             conversion_done_flag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_wait_one_cycle: assert property (
		$fell(avs_waitrequest) |=> !ce || avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_req_answered: assert property (
		ce && (avs_read || avs_write) && avs_waitrequest |=> !ce || !avs_waitrequest)
		else $error("request not answered in one cycle");
	a_start_pulse: assert property (conv_start |=> !conv_start)
		else $error("start pulse longer than one cycle");
	a_abort_pulse: assert property (conv_abort |=> !conv_abort)
		else $error("abort pulse longer than one cycle");
	a_start_abort_excl: assert property (!(conv_start && conv_abort))
		else $error("start and abort together");
	a_off_no_mux: assert property (
		!converter_on && !$past(converter_on)
		|-> pos_mux_select == SRC_NONE && neg_mux_select == SRC_NONE)
		else $error("multiplexer connected while converter off");
	a_mux_onehot: assert property (
		$onehot0(pos_mux_select) && $onehot0(neg_mux_select))
		else $error("multiplexer select not one-hot");
	a_rc_no_tick: assert property (conv_clk_use_rc [*3] |-> !conv_clk_tick)
		else $error("divided tick while rc clock selected");
	a_off_no_tick: assert property (!converter_on [*3] |-> !conv_clk_tick)
		else $error("conversion clock tick while converter off");
	a_done_cause: assert property (
		$rose(conversion_done_flag) |-> $past(conv_done))
		else $error("done flag set without converter completion");

	cover property (conv_start);
	cover property (conv_abort);
	cover property ($rose(conversion_done_flag));
endmodule

bind adcc_top adcc_top_monitor u_adcc_top_monitor (
	.clk                  (clk),
	.rst                  (rst),
	.ce                   (ce),
	.avs_read             (avs_read),
	.avs_write            (avs_write),
	.avs_waitrequest      (avs_waitrequest),
	.conv_done            (conv_done),
	.converter_on         (converter_on),
	.conv_start           (conv_start),
	.conv_abort           (conv_abort),
	.conv_clk_tick        (conv_clk_tick),
	.conv_clk_use_rc      (conv_clk_use_rc),
	.pos_mux_select       (pos_mux_select),
	.neg_mux_select       (neg_mux_select),
	.conversion_done_flag (conversion_done_flag)
);

`default_nettype wire

/* adcc_top_tb_top.sv */
// testbench for the converter control block
`timescale 1ns/1ps
`default_nettype none

module adcc_top_tb_top
	import adcc_pkg::*;
;
	localparam logic [4:0] A0 = {1'b0, OFF_CONTROL_ZERO};
	localparam logic [4:0] A1 = {1'b0, OFF_CONTROL_ONE};
	localparam logic [4:0] A2 = {1'b0, OFF_CONTROL_TWO};
	localparam logic [4:0] A3 = {1'b0, OFF_RESULT_HIGH};
	localparam logic [4:0] A4 = OFF_RESULT_LOW[4:0];

	logic             clk = 1'b0;
	logic             rst = 1'b1;
	logic             ce = 1'b1;
	logic [4:0]       avs_address = 5'h00;
	logic             avs_read = 1'b0;
	logic             avs_write = 1'b0;
	logic [31:0]      avs_writedata = 32'h0;
	logic [3:0]       avs_byteenable = 4'hF;
	logic [31:0]      avs_readdata;
	logic             avs_waitrequest;
	logic [TRG_W-1:0] trigger_in = '0;
	logic             conv_done, conv_sign, conv_start, conv_abort, tick, use_rc, neg_ref_pin;
	logic             converter_on, conversion_done_flag;
	logic [11:0]      conv_magnitude;
	logic [SRC_W-1:0] pos_mux_select, neg_mux_select;
	logic [1:0]       pos_ref_select;
	logic [7:0]       lat = 8'h01;
	logic [12:0]      smp = 13'h0000;
	logic [31:0]      rdv;
	int               error_cnt = 0;
	int               comparisons = 0;
	int               i, n, ev;
	logic [4:0]       pc [13] = '{5'h00, 5'h0D, 5'h15, 5'h1F, 5'h1E, 5'h1D, 5'h1C,
		5'h19, 5'h18, 5'h16, 5'h14, 5'h0E, 5'h1B};
	int               pi [13] = '{0, 13, 21, 27, 22, 26, 23, 24, 25, -1, -1, -1, -1};
	logic [7:0]       nc [4] = '{8'h00, 8'h0D, 8'h0E, 8'h0F};
	int               ni [4] = '{0, 13, 21, 28};
	int               ti [16] = '{-1, 0, 1, -1, 2, 3, 4, 5, 6, 7, -1, -1, -1, 8, 9, 10};
	int               dv [8] = '{2, 8, 32, 0, 4, 16, 64, 0};
	logic             cw [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
	logic             cf [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
	logic [12:0]      cs [5] = '{13'h0933, 13'h0933, 13'h1FFF, 13'h1933, 13'h0933};
	logic [7:0]       eh [5] = '{8'h93, 8'h09, 8'hF0, 8'h93, 8'h02};
	logic [7:0]       el [5] = '{8'h30, 8'h33, 8'h01, 8'h01, 8'h4C};

	adcc_top u_adcc_top (.clk(clk), .rst(rst), .ce(ce), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .trigger_in(trigger_in), .conv_done(conv_done),
		.conv_sign(conv_sign), .conv_magnitude(conv_magnitude), .converter_on(converter_on),
		.conv_start(conv_start), .conv_abort(conv_abort), .conv_clk_tick(tick),
		.conv_clk_use_rc(use_rc), .pos_mux_select(pos_mux_select),
		.neg_mux_select(neg_mux_select), .neg_ref_pin(neg_ref_pin),
		.pos_ref_select(pos_ref_select), .conversion_done_flag(conversion_done_flag));

	adcc_conv_model u_adcc_conv_model (.clk(clk), .rst(rst), .conv_start(conv_start),
		.conv_abort(conv_abort), .latency(lat), .sample(smp), .conv_done(conv_done),
		.conv_sign(conv_sign), .conv_magnitude(conv_magnitude));

	initial begin
		forever #20 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		if (error_cnt == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
		input logic [3:0] be);
		int k;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= be;
		avs_read <= !wr;
		avs_write <= wr;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0) break;
		end
		if (k == 50) begin
			error_cnt++;
			tally_and_finish();
		end
		rdv = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask

	task automatic rdc(input string nm, input logic [4:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, 4'hF);
		check(nm, rdv, {24'h0, e});
	endtask

	task automatic wait_idle();
		int k;
		for (k = 0; k < 100; k++) begin
			bus(1'b0, A0, 8'h00, 4'hF);
			if (rdv[POS_GO_DONE] === 1'b0) break;
		end
		if (k == 100) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask

	function automatic logic [SRC_W-1:0] pe(input int k);
		return (k < 0) ? SRC_NONE : (SRC_ONE << k);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rdc("ctl0", A0, 8'h00);
		rdc("ctl1", A1, 8'h00);
		rdc("ctl2", A2, 8'h00);
		rdc("unmapped", 5'h14, 8'h00);
		wr(A1, 8'hFF);
		rdc("ctl1", A1, 8'hF7);
		bus(1'b1, A2, 8'h5A, 4'h0);
		rdc("ctl2 lane", A2, 8'h00);
		wr(A0, 8'h01);
		for (i = 0; i < 8; i++) begin
			wr(A1, {1'b0, i[2:0], 1'b0, i[0], i[1:0]});
			repeat (2) @(posedge clk);
			check("pos ref", pos_ref_select, i[1:0]);
			check("neg ref", neg_ref_pin, i[0]);
			check("rc", use_rc, i[2:0] == 3'h3 || i[2:0] == 3'h7);
			n = 0;
			ev = (dv[i] == 0) ? 0 : 128 / dv[i];
			repeat (128) begin
				@(posedge clk);
				n += tick;
			end
			check("ticks", n >= ev - 1 && n <= ev + 1, 1'b1);
			if (i == 0) begin
				ce <= 1'b0;
				@(posedge clk);
				n = tick;
				repeat (3) @(posedge clk);
				check("frozen tick", tick, n[0]);
				ce <= 1'b1;
			end
		end
		for (i = 0; i < 13; i++) begin
			wr(A0, {1'b0, pc[i], 2'b01});
			repeat (2) @(posedge clk);
			check("pos mux", pos_mux_select, pe(pi[i]));
		end
		for (i = 0; i < 4; i++) begin
			wr(A2, nc[i]);
			repeat (2) @(posedge clk);
			check("neg mux", neg_mux_select, pe(ni[i]));
		end
		wr(A0, 8'h34);
		repeat (2) @(posedge clk);
		check("off pos", pos_mux_select, SRC_NONE);
		check("off neg", neg_mux_select, SRC_NONE);
		check("off", converter_on, 1'b0);
		wr(A0, 8'h02);
		rdc("go off", A0, 8'h00);
		for (i = 0; i < 5; i++) begin
			lat <= i[0] ? 8'd1 : 8'd40;
			smp <= cs[i];
			wr(A1, {cf[i], 7'h00});
			wr(A0, {cw[i], 7'h03});
			if (!i[0]) begin
				rdc("busy", A0, {cw[i], 7'h03});
				check("flag clr", conversion_done_flag, 1'b0);
				rdc("cleared", A3, 8'h00);
			end
			wait_idle();
			check("done flag", conversion_done_flag, 1'b1);
			rdc("res hi", A3, eh[i]);
			rdc("res lo", A4, el[i]);
		end
		lat <= 8'd200;
		wr(A0, 8'h03);
		wr(A0, 8'h01);
		rdc("abort hi", A3, 8'h00);
		repeat (220) @(posedge clk);
		rdc("abort go", A0, 8'h01);
		rdc("abort lo", A4, 8'h00);
		lat <= 8'd40;
		for (i = 0; i < 16; i++) begin
			wr(A2, {i[3:0], 4'h0});
			trigger_in <= (ti[i] < 0) ? '1 : ~(11'h001 << ti[i]);
			repeat (4) @(posedge clk);
			rdc("no trig", A0, 8'h01);
			if (ti[i] >= 0) begin
				trigger_in <= '1;
				repeat (4) @(posedge clk);
				rdc("trig", A0, 8'h03);
				wait_idle();
			end
			trigger_in <= '0;
		end
		tally_and_finish();
	end

	initial begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		tally_and_finish();
	end
endmodule

`default_nettype wire
